// >>> dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import uvrb_pkg::*;

    localparam int LIMIT = 30000;
    logic clock, sys_rst, soft_rst, cfg_return, meas_done, meas_busy;
    logic [RAW_W-1:0] chan_a_raw, chan_b_raw, chan_c_raw;
    logic adc_overdrive, external_sync_start_stop_mode;
    logic conv_time_counter_enable, conv_start, conv_run;
    logic standby_ctrl, power_down_ctrl, rd_valid;
    logic [TEMP_W-1:0] temp_raw;
    logic [7:0] osr_byte, rd_data, exp_b;
    logic rd_start, rd_stop, rd_byte_req, rd_byte_sel;
    logic [2:0] rd_addr;
    logic [7:0] notes[$];
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    uvrb_top i_dut (.clock, .sys_rst, .soft_rst, .cfg_return, .meas_done,
        .meas_busy, .chan_a_raw, .chan_b_raw, .chan_c_raw, .adc_overdrive,
        .temp_raw, .external_sync_start_stop_mode,
        .conv_time_counter_enable, .conv_start, .conv_run, .standby_ctrl,
        .power_down_ctrl, .osr_byte, .rd_start, .rd_stop, .rd_byte_req,
        .rd_addr, .rd_byte_sel, .rd_data, .rd_valid);
    uvrb_host i_host (.clock, .rd_data, .rd_valid, .rd_start, .rd_stop,
        .rd_byte_req, .rd_addr, .rd_byte_sel);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
        miscompares += notes.size();
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // every answer byte is matched against the oldest note
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (rd_valid === 1'b1) begin
            checks_done++;
            exp_b = notes.size() ? notes.pop_front() : 8'hXX;
            if (rd_data !== exp_b) begin
                miscompares++;
                $display("wrong value at %0t: %h vs %h", $time, rd_data, exp_b);
            end
        end
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] sat(input logic [16:0] r);
        return r[16] ? CHAN_SAT : r[15:0];
    endfunction

    function automatic logic [16:0] rnd(input logic o);
        return {o, 16'($urandom)};
    endfunction

    task automatic rw(input logic [2:0] a, input logic [15:0] e);
        logic [15:0] w;
        notes.push_back(e[7:0]);
        notes.push_back(e[15:8]);
        i_host.word(a, w);
    endtask

    // status byte alone: the paired low byte would clear the flags first
    task automatic rs(input logic [7:0] f);
        logic [2:0] m;
        logic [7:0] b;
        m = 3'($urandom);
        @(posedge clock);
        {meas_busy, standby_ctrl, power_down_ctrl} <= m;
        @(posedge clock);
        notes.push_back(f | {5'h00, m});
        i_host.fetch(ADDR_STATUS, 1'b1, b);
    endtask

    // overdrive comes a cycle ahead, so only the gathering can catch it;
    // the inputs turn to noise once captured
    task automatic meas(input logic [16:0] a, b, c, input logic ovd,
                        input logic [11:0] t);
        @(posedge clock);
        adc_overdrive <= ovd;
        @(posedge clock);
        chan_a_raw <= a;
        chan_b_raw <= b;
        chan_c_raw <= c;
        adc_overdrive <= 1'b0;
        temp_raw <= t;
        meas_done <= 1'b1;
        @(posedge clock);
        meas_done <= 1'b0;
        chan_a_raw <= 17'($urandom);
        chan_b_raw <= 17'($urandom);
        chan_c_raw <= 17'($urandom);
        temp_raw <= 12'($urandom);
    endtask

    // option byte alone, changed just before it is fetched
    task automatic ro();
        logic [7:0] b;
        @(posedge clock);
        osr_byte <= 8'($urandom);
        @(posedge clock);
        notes.push_back(osr_byte);
        i_host.fetch(ADDR_STATUS, 1'b0, b);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        logic [16:0] a, b;
        logic [11:0] t;
        logic [15:0] e;
        int k, n;
        void'($urandom(50));
        {sys_rst, soft_rst, cfg_return, meas_done, meas_busy} = 5'h10;
        chan_a_raw = 17'($urandom);
        chan_b_raw = 17'($urandom);
        chan_c_raw = 17'($urandom);
        {adc_overdrive, external_sync_start_stop_mode} = 2'h0;
        {conv_time_counter_enable, conv_start, conv_run} = 3'h0;
        {standby_ctrl, power_down_ctrl} = 2'h0;
        temp_raw = 12'($urandom);
        osr_byte = 8'($urandom);
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        i_host.frame(1'b1);
        rw(ADDR_STATUS, {8'h00, osr_byte});
        rw(ADDR_TEMP, WORD_RST);
        rw(3'h7, WORD_RST);
        i_host.frame(1'b0);
        a = rnd(1'b0);
        b = rnd(1'b1);
        t = 12'($urandom);
        meas(a, b, a, 1'b1, t);
        i_host.frame(1'b1);
        rs(8'h68);
        rw(ADDR_CHAN_A, sat(a));
        rw(ADDR_CHAN_B, sat(b));
        rw(ADDR_CHAN_C, sat(a));
        rw(ADDR_TEMP, {TEMP_PAD, t});
        rs(8'h60);
        i_host.frame(1'b0);
        meas(rnd(1'b0), rnd(1'b0), rnd(1'b0), 1'b0, t);
        a = rnd(1'b0);
        meas(a, a, a, 1'b0, t);
        i_host.frame(1'b1);
        rw(ADDR_CHAN_A, sat(a));
        rs(8'h10);
        rs(8'h00);
        i_host.frame(1'b0);
        // a measurement lands while a read is still open
        i_host.frame(1'b1);
        b = rnd(1'b0);
        meas(b, rnd(1'b1), b, 1'b1, t);
        rs(8'h08);
        rw(ADDR_CHAN_A, sat(a));
        i_host.frame(1'b0);
        i_host.frame(1'b1);
        rs(8'h60);
        rw(ADDR_CHAN_A, sat(b));
        i_host.frame(1'b0);
        external_sync_start_stop_mode <= 1'b1;
        for (k = 0; k < 3; k++) begin
            n = (k == 1) ? 4095 : 4096;
            @(posedge clock);
            conv_time_counter_enable <= (k != 0);
            conv_start <= 1'b1;
            @(posedge clock);
            conv_start <= 1'b0;
            conv_run <= 1'b1;
            repeat (n) @(posedge clock);
            conv_run <= 1'b0;
            meas(a, a, a, 1'b0, t);
            i_host.frame(1'b1);
            e = (k == 2) ? {TEMP_PAD, t} : WORD_RST;
            rs(8'h08);
            rw(ADDR_TEMP, e);
            rw(ADDR_CONV_LO, (k != 0) ? n[15:0] : WORD_RST);
            rw(ADDR_CONV_HI, {8'h00, (k != 0) ? n[23:16] : 8'h00});
            i_host.frame(1'b0);
        end
        external_sync_start_stop_mode <= 1'b0;
        for (k = 0; k < 2; k++) begin
            meas(rnd(1'b1), rnd(1'b0), rnd(1'b0), 1'b1, t);
            @(posedge clock);
            soft_rst <= (k == 0);
            cfg_return <= (k == 1);
            @(posedge clock);
            soft_rst <= 1'b0;
            cfg_return <= 1'b0;
            i_host.frame(1'b1);
            rw(ADDR_CHAN_A, WORD_RST);
            rw(ADDR_CONV_LO, WORD_RST);
            rs(8'h00);
            ro();
            i_host.frame(1'b0);
        end
        repeat (3) @(posedge clock);
        end_of_test();
    end
endmodule

// >>> dv/uvrb_host.sv
module uvrb_host (
    input wire logic clock,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic rd_start,
    output logic rd_stop,
    output logic rd_byte_req,
    output logic [2:0] rd_addr,
    output logic rd_byte_sel
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        rd_start = 1'b0;
        rd_stop = 1'b0;
        rd_byte_req = 1'b0;
        rd_addr = 3'h0;
        rd_byte_sel = 1'b0;
    end

    // open a read (start) or close it (stop), one cycle pulse
    task automatic frame(input logic open);
        @(posedge clock);
        rd_start <= open;
        rd_stop <= !open;
        @(posedge clock);
        rd_start <= 1'b0;
        rd_stop <= 1'b0;
    endtask

    task automatic fetch(input logic [2:0] a, input logic s,
                         output logic [7:0] b);
        int n;
        @(posedge clock);
        rd_byte_req <= 1'b1;
        rd_addr <= a;
        rd_byte_sel <= s;
        @(posedge clock);
        rd_byte_req <= 1'b0;
        for (n = 0; n < 4; n++) begin
            @(posedge clock);
            if (rd_valid === 1'b1) break;
        end
        b = rd_data;
        // released select lines flip so stale values are never trusted
        rd_addr <= ~a;
        rd_byte_sel <= ~s;
    endtask

    // low byte first, the word is put together here
    task automatic word(input logic [2:0] a, output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        fetch(a, 1'b0, lo);
        fetch(a, 1'b1, hi);
        w = {hi, lo};
    endtask
endmodule

// >>> src/uvrb_ctcnt.sv
module uvrb_ctcnt (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic run,
    output logic [uvrb_pkg::CONV_W-1:0] count,
    output logic ovf
);
    import uvrb_pkg::*;

    typedef struct packed {
        logic [CONV_W-1:0] count;
        logic ovf;
    } uvrb_ct_t;

    uvrb_ct_t st;
    uvrb_ct_t next_st;

    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.count = CONV_RST;
            next_st.ovf = 1'b0;
        end else if (run) begin
            if (st.count == CONV_MAX) begin
                next_st.count = CONV_RST;
                next_st.ovf = 1'b1;
            end else begin
                next_st.count = st.count + CONV_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '{count: CONV_RST, ovf: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign ovf = st.ovf;

    property p_wrap;
        @(posedge clock) disable iff (sys_rst)
        (run && !clr && st.count == CONV_MAX) |=> (ovf && count == CONV_RST);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("conversion counter did not wrap with overflow");
endmodule

// >>> src/uvrb_pkg.sv
package uvrb_pkg;

    // register indices on the serial read port
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_TEMP = 3'h1;
    localparam logic [2:0] ADDR_CHAN_A = 3'h2;
    localparam logic [2:0] ADDR_CHAN_B = 3'h3;
    localparam logic [2:0] ADDR_CHAN_C = 3'h4;
    localparam logic [2:0] ADDR_CONV_LO = 3'h5;
    localparam logic [2:0] ADDR_CONV_HI = 3'h6;

    // widths
    localparam int NUM_CHAN = 3;
    localparam int CHAN_W = 16;
    localparam int RAW_W = 17;
    localparam int TEMP_W = 12;
    localparam int CONV_W = 24;

    // values
    localparam logic [15:0] CHAN_SAT = 16'hFFFF;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] TEMP_PAD = 4'h0;
    localparam logic [23:0] CONV_RST = 24'h000000;
    localparam logic [23:0] CONV_ONE = 24'h000001;
    localparam logic [23:0] CONV_MAX = 24'hFFFFFF;
    // least conversion time, in system clocks, for a valid temperature
    localparam logic [23:0] TEMP_MIN_CLOCKS = 24'h001000;

    // status byte bit positions
    localparam int ST_CONV_OVF = 7;
    localparam int ST_RES_OVF = 6;
    localparam int ST_ADC_OVF = 5;
    localparam int ST_LOST = 4;
    localparam int ST_NEW = 3;
    localparam int ST_NOTREADY = 2;
    localparam int ST_STANDBY = 1;
    localparam int ST_POWER_DOWN = 0;

    typedef enum logic {
        UVRB_RD_IDLE = 1'b0,
        UVRB_RD_OPEN = 1'b1
    } uvrb_rd_t;

endpackage

// >>> src/uvrb_sat.sv
module uvrb_sat (
    input wire logic [uvrb_pkg::RAW_W-1:0] raw,
    output logic [uvrb_pkg::CHAN_W-1:0] sat,
    output logic ovf
);
    import uvrb_pkg::*;

    // a count past the register range holds at full scale, never wraps
    always_comb begin
        ovf = raw[RAW_W-1];
        sat = ovf ? CHAN_SAT : raw[CHAN_W-1:0];
    end
endmodule

// >>> src/uvrb_top.sv
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - converter overdrive during a measurement sets its flag without overflow.
// - overflow flags always describe the results in the output registers.
// - measurement end stores channel counts in buffers and sets new flag.
// - start of any read copies all buffers to the output registers.
// - while a read is open, no newer buffer data reaches outputs.
// - reading status or any result register clears the new flag.
// - measurement ending over unread buffer overwrites it and sets lost flag.
// - only a status read clears the lost flag.
// - standby and power-down status bits mirror the internal control signals.
// - each 16-bit register goes out least significant byte first.
// - temperature occupies low 12 bits, upper four bits read zero.
// - short conversion times in free-running modes still give a temperature of lower resolution.
// - sync mode with time counter off gives no temperature.
// - sync mode temperature valid only for at least 4096 clocks.
// - power-on, software reset or return to configuration clears outputs.
// - an overflowing channel result saturates at full scale.
// - time counter overflow sets its flag and restarts at zero.
////////////////////////////////////////////////////////////////////////////////
module uvrb_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic cfg_return,
    input wire logic meas_done,
    input wire logic meas_busy,
    input wire logic [uvrb_pkg::RAW_W-1:0] chan_a_raw,
    input wire logic [uvrb_pkg::RAW_W-1:0] chan_b_raw,
    input wire logic [uvrb_pkg::RAW_W-1:0] chan_c_raw,
    input wire logic adc_overdrive,
    input wire logic [uvrb_pkg::TEMP_W-1:0] temp_raw,
    input wire logic external_sync_start_stop_mode,
    input wire logic conv_time_counter_enable,
    input wire logic conv_start,
    input wire logic conv_run,
    input wire logic standby_ctrl,
    input wire logic power_down_ctrl,
    input wire logic [7:0] osr_byte,
    input wire logic rd_start,
    input wire logic rd_stop,
    input wire logic rd_byte_req,
    input wire logic [2:0] rd_addr,
    input wire logic rd_byte_sel,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    import uvrb_pkg::*;

    typedef struct packed {
        uvrb_rd_t rd_state;
        logic [NUM_CHAN-1:0][CHAN_W-1:0] buf_chan;
        logic [CHAN_W-1:0] buf_temp;
        logic [CONV_W-1:0] buf_conv;
        logic buf_res_ovf;
        logic buf_adc_ovf;
        logic buf_conv_ovf;
        logic buf_fresh;
        logic adc_acc;
        logic [NUM_CHAN-1:0][CHAN_W-1:0] out_chan;
        logic [CHAN_W-1:0] out_temp;
        logic [CONV_W-1:0] out_conv;
        logic out_res_ovf;
        logic out_adc_ovf;
        logic out_conv_ovf;
        logic new_results_flag;
        logic lost_results_flag;
        logic standby_mirror_bit;
        logic power_down_mirror_bit;
        logic [7:0] rd_data;
        logic rd_valid;
    } uvrb_state_t;

    uvrb_state_t st;
    uvrb_state_t next_st;

    logic clr;
    logic [NUM_CHAN-1:0][RAW_W-1:0] raw;
    logic [NUM_CHAN-1:0][CHAN_W-1:0] sat;
    logic [NUM_CHAN-1:0] chan_ovf;
    logic [CONV_W-1:0] conv_count;
    logic conv_ovf;
    logic temp_ok;
    logic [7:0] status_byte;
    logic [CHAN_W-1:0] rd_word;
    logic status_read;
    logic result_read;

    ////////////////////////////////////////////////////////////////////////////
    // capture-side helpers

    assign clr = sys_rst | soft_rst | cfg_return;
    assign raw[0] = chan_a_raw;
    assign raw[1] = chan_b_raw;
    assign raw[2] = chan_c_raw;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            uvrb_sat u_sat (
                .raw(raw[gi]),
                .sat(sat[gi]),
                .ovf(chan_ovf[gi])
            );
        end
    endgenerate

    // the counter only runs on externally framed conversions
    uvrb_ctcnt u_ctcnt (
        .clock(clock),
        .sys_rst(sys_rst),
        .clr(clr | conv_start),
        .run(conv_run & external_sync_start_stop_mode &
             conv_time_counter_enable),
        .count(conv_count),
        .ovf(conv_ovf)
    );

    // temperature gate: free-running modes always keep it, even when a
    // short conversion leaves it coarse
    always_comb begin
        if (!external_sync_start_stop_mode) begin
            temp_ok = 1'b1;
        end else if (!conv_time_counter_enable) begin
            temp_ok = 1'b0;
        end else begin
            temp_ok = (conv_count >= TEMP_MIN_CLOCKS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read-side helpers

    always_comb begin
        status_byte = BYTE_RST;
        status_byte[ST_CONV_OVF] = st.out_conv_ovf;
        status_byte[ST_RES_OVF] = st.out_res_ovf;
        status_byte[ST_ADC_OVF] = st.out_adc_ovf;
        status_byte[ST_LOST] = st.lost_results_flag;
        status_byte[ST_NEW] = st.new_results_flag;
        status_byte[ST_NOTREADY] = meas_busy;
        status_byte[ST_STANDBY] = st.standby_mirror_bit;
        status_byte[ST_POWER_DOWN] = st.power_down_mirror_bit;
    end

    always_comb begin
        case (rd_addr)
            ADDR_STATUS: rd_word = {status_byte, osr_byte};
            ADDR_TEMP: rd_word = st.out_temp;
            ADDR_CHAN_A: rd_word = st.out_chan[0];
            ADDR_CHAN_B: rd_word = st.out_chan[1];
            ADDR_CHAN_C: rd_word = st.out_chan[2];
            ADDR_CONV_LO: rd_word = st.out_conv[15:0];
            ADDR_CONV_HI: rd_word = {BYTE_RST, st.out_conv[23:16]};
            default: rd_word = WORD_RST;
        endcase
    end

    assign status_read = rd_byte_req && (rd_addr == ADDR_STATUS);
    assign result_read = rd_byte_req && (rd_addr >= ADDR_TEMP) &&
                         (rd_addr <= ADDR_CONV_HI);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        next_st.rd_valid = rd_byte_req;
        // low byte for select 0, so the host sees the LSB first
        next_st.rd_data = rd_byte_sel ? rd_word[15:8] : rd_word[7:0];
        next_st.standby_mirror_bit = standby_ctrl;
        next_st.power_down_mirror_bit = power_down_ctrl;

        // clear-side of the flags first, so that sets below win
        if (status_read || result_read) begin
            next_st.new_results_flag = 1'b0;
        end
        if (status_read) begin
            next_st.lost_results_flag = 1'b0;
        end

        // overdrive is gathered over the whole measurement
        if (adc_overdrive) begin
            next_st.adc_acc = 1'b1;
        end

        // a read that starts while the bank is idle takes the buffers; a
        // repeated start inside the same read does not
        if (rd_start && st.rd_state == UVRB_RD_IDLE) begin
            next_st.out_chan = st.buf_chan;
            next_st.out_temp = st.buf_temp;
            next_st.out_conv = st.buf_conv;
            next_st.out_res_ovf = st.buf_res_ovf;
            next_st.out_adc_ovf = st.buf_adc_ovf;
            next_st.out_conv_ovf = st.buf_conv_ovf;
            next_st.buf_fresh = 1'b0;
        end

        case (st.rd_state)
            UVRB_RD_IDLE: begin
                if (rd_start && !rd_stop) begin
                    next_st.rd_state = UVRB_RD_OPEN;
                end
            end
            UVRB_RD_OPEN: begin
                if (rd_stop) begin
                    next_st.rd_state = UVRB_RD_IDLE;
                end
            end
            default: next_st.rd_state = UVRB_RD_IDLE;
        endcase

        if (meas_done) begin
            next_st.buf_chan = sat;
            next_st.buf_res_ovf = |chan_ovf;
            next_st.buf_adc_ovf = st.adc_acc | adc_overdrive;
            next_st.buf_conv_ovf = conv_ovf;
            next_st.buf_conv = conv_time_counter_enable ? conv_count
                                                        : CONV_RST;
            next_st.buf_temp = temp_ok ? {TEMP_PAD, temp_raw}
                                       : WORD_RST;
            next_st.adc_acc = 1'b0;
            next_st.buf_fresh = 1'b1;
            next_st.new_results_flag = 1'b1;
            if (st.buf_fresh) begin
                next_st.lost_results_flag = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock) begin
        if (clr) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign rd_valid = st.rd_valid;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_new_set;
        @(posedge clock) disable iff (sys_rst)
        (meas_done && !clr) |=> st.new_results_flag;
    endproperty
    a_new_set: assert property (p_new_set)
        else $error("new flag not set after measurement end");

    property p_lost_set;
        @(posedge clock) disable iff (sys_rst)
        (meas_done && st.buf_fresh && !clr) |=> st.lost_results_flag;
    endproperty
    a_lost_set: assert property (p_lost_set)
        else $error("overwritten buffer did not raise lost flag");

    property p_lost_keep;
        @(posedge clock) disable iff (sys_rst)
        (st.lost_results_flag && !status_read && !clr)
            |=> st.lost_results_flag;
    endproperty
    a_lost_keep: assert property (p_lost_keep)
        else $error("lost flag cleared without a status read");

    property p_new_clear;
        @(posedge clock) disable iff (sys_rst)
        (result_read && !meas_done && !clr) |=> !st.new_results_flag;
    endproperty
    a_new_clear: assert property (p_new_clear)
        else $error("result read did not clear new flag");

    property p_copy;
        @(posedge clock) disable iff (sys_rst)
        (rd_start && st.rd_state == UVRB_RD_IDLE && !clr)
            |=> (st.out_chan == $past(st.buf_chan)) &&
                (st.out_res_ovf == $past(st.buf_res_ovf));
    endproperty
    a_copy: assert property (p_copy)
        else $error("read start did not copy the buffers");

    property p_hold;
        @(posedge clock) disable iff (sys_rst)
        (st.rd_state == UVRB_RD_OPEN && !rd_stop && !clr)
            |=> $stable(st.out_chan) && $stable(st.out_temp);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output registers changed during an open read");

    property p_sat;
        @(posedge clock) disable iff (sys_rst)
        (meas_done && chan_a_raw[RAW_W-1] && !clr)
            |=> st.buf_chan[0] == CHAN_SAT;
    endproperty
    a_sat: assert property (p_sat)
        else $error("overflowed channel did not saturate");

    property p_no_temp;
        @(posedge clock) disable iff (sys_rst)
        (meas_done && external_sync_start_stop_mode &&
         !conv_time_counter_enable && !clr) |=> st.buf_temp == WORD_RST;
    endproperty
    a_no_temp: assert property (p_no_temp)
        else $error("temperature kept with time counter disabled");

    property p_temp_pad;
        @(posedge clock) disable iff (sys_rst)
        st.out_temp[15:12] == TEMP_PAD;
    endproperty
    a_temp_pad: assert property (p_temp_pad)
        else $error("temperature upper bits not zero");

    property p_clear;
        @(posedge clock) disable iff (sys_rst)
        (soft_rst || cfg_return)
            |=> (st.out_chan == '0) && !st.new_results_flag && !rd_valid;
    endproperty
    a_clear: assert property (p_clear)
        else $error("reset did not clear the output bank");

    property p_mirror;
        @(posedge clock) disable iff (sys_rst)
        !clr |=> st.standby_mirror_bit == $past(standby_ctrl);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("standby mirror does not follow control signal");
endmodule
